// ==== bench/cpualu_monitor.sv ====
// Port checks for the datapath: APB answer, sleep pulse, oscillator and wake.
`timescale 1ns/1ps
`include "cpualu_defs.svh"
module cpualu_monitor #(
	parameter int FILE_DEPTH = 128,
	parameter int PRESC_W    = 8
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        osc_run,
	input wire logic        watchdog_clear
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr_acc   = psel && penable && pwrite;
	wire sleep_wr = wr_acc && paddr == `CPUALU_OFF_INSTR && pwdata[15:12] == `CPUALU_OP_SLEEP;
	wire wake_wr  = wr_acc && paddr == `CPUALU_OFF_WAKE && pwdata[0];
	wire mapped   = paddr[1:0] == 2'h0 && paddr <= `CPUALU_OFF_WAKE;
	sequence s_sleep_taken;
		sleep_wr && osc_run;
	endsequence
	sequence s_clear_pulse;
		watchdog_clear ##1 (!watchdog_clear && !osc_run);
	endsequence
	access_ready_a: assert property (psel && penable |-> pready)
		else $error("ready missing in access");
	setup_idle_a: assert property (psel && !penable |-> !pready)
		else $error("ready in setup");
	mapped_ok_a: assert property (pready && mapped |-> !pslverr)
		else $error("error on mapped address");
	unmapped_err_a: assert property (pready && !mapped |->
		pslverr && (pwrite || prdata == 32'h0000_0000))
		else $error("unmapped address not refused");
	sleep_pulse_a: assert property (s_sleep_taken |=> s_clear_pulse)
		else $error("sleep pulse wrong");
	pulse_cause_a: assert property ($rose(watchdog_clear) |-> $past(sleep_wr && osc_run))
		else $error("clear without sleep");
	osc_hold_a: assert property (!osc_run && !wake_wr |=> !osc_run)
		else $error("woke without wake");
	wake_run_a: assert property (!osc_run && wake_wr |=> osc_run)
		else $error("wake ignored");
endmodule // cpualu_monitor

bind cpualu_core cpualu_monitor #(.FILE_DEPTH(FILE_DEPTH), .PRESC_W(PRESC_W)) u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.osc_run(osc_run), .watchdog_clear(watchdog_clear));

// ==== bench/tb.sv ====
// Self-checking bench that runs the instruction subset through the APB registers.
`timescale 1ns/1ps
`include "cpualu_defs.svh"
module tb;
	localparam logic [11:0] a_in = `CPUALU_OFF_INSTR;
	localparam logic [11:0] a_f  = `CPUALU_OFF_FILE;
	localparam logic [11:0] a_w  = `CPUALU_OFF_WREG;
	localparam logic [11:0] a_st = `CPUALU_OFF_STATUS;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r;
	logic        pready, pslverr, osc_run, watchdog_clear;
	int          fails = 0, num_checks = 0;
	bit          keep = 1'b0, held = 1'b0;
	always #12.5 pclk = ~pclk;
	cpualu_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_run(osc_run), .watchdog_clear(watchdog_clear));
	task automatic chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// A transfer opens with an idle edge unless the one before kept psel up for a
	// back-to-back setup, so psel is never assigned twice at one edge.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
		if (!held)
			@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		penable <= 1'b0;
		if (!keep)
			psel <= 1'b0;
		held = keep;
		keep = 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 16'h0000);
		chk(r, {24'h0, e});
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		xfer(1'b1, a, d);
	endtask
	function automatic logic [15:0] ins(input logic [3:0] op, input logic [7:0] lo);
		return {op, 4'h0, lo};
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(a_st, 8'h18);
		wr(a_st, 16'h0019);
		wr(a_f, 16'h0002);
		wr(a_in, ins(4'h1, 8'h80));
		rd(a_f, 8'h81);
		rd(a_st, 8'h18);
		wr(a_w, 16'h0005);
		wr(a_f, 16'h0013);
		wr(a_in, ins(4'h2, 8'h00));
		rd(a_w, 8'h0e);
		rd(a_st, 8'h19);
		wr(a_w, 16'h0020);
		wr(a_in, ins(4'h3, 8'h10));
		rd(a_st, 8'h1a);
		wr(a_in, ins(4'h3, 8'hf0));
		rd(a_st, 8'h1f);
		wr(a_f, 16'h00a5);
		wr(a_in, ins(4'h4, 8'h00));
		rd(a_w, 8'h5a);
		rd(a_st, 8'h1f);
		wr(a_st, 16'h001b);
		wr(a_in, ins(4'h5, 8'h5a));
		rd(a_st, 8'h1f);
		wr(a_w, 16'h000f);
		wr(a_f, 16'h00ff);
		wr(a_in, ins(4'h6, 8'h80));
		rd(a_f, 8'hf0);
		rd(a_st, 8'h1b);
		repeat (300) @(posedge pclk);
		xfer(1'b0, `CPUALU_OFF_WDOG, 16'h0000);
		chk({31'h0, r[7:0] != 8'h00}, 32'h1);
		wr(a_st, 16'h000b);
		wr(a_in, ins(4'h7, 8'h00));
		rd(a_st, 8'h33);
		rd(`CPUALU_OFF_WDOG, 8'h00);
		chk({31'h0, osc_run}, 32'h0);
		wr(a_in, ins(4'h5, 8'hff));
		wr(`CPUALU_OFF_WAKE, 16'h0001);
		rd(a_w, 8'h0f);
		chk({31'h0, osc_run}, 32'h1);
		keep = 1'b1;
		wr(a_in, ins(4'h8, 8'h00));
		keep = 1'b1;
		rd(a_st, 8'h53);
		rd(a_st, 8'h13);
		rd(a_w, 8'h0f);
		rd(12'h01c, 8'h00);
		chk({31'h0, err}, 32'h1);
		print_verdict();
	end
	initial begin
		#100_000;
		fails++;
		print_verdict();
	end
endmodule // tb

// ==== verilog/cpualu_core.sv ====
// Execution datapath for a subset of an 8-bit core instruction set, with an APB slave.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "cpualu_defs.svh"

module cpualu_core
	import cpualu_pkg::*;
#(
	parameter int FILE_DEPTH = 128,
	parameter int PRESC_W    = 8
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             osc_run,
	output logic             watchdog_clear
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} + {1'b0, ~b} + 9'h001;
		low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		// Carry out of the complemented add is the inverted borrow.
		sub8 = {low[4], full[8], full[7:0]};
	endfunction

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = v == 8'h00;
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic [7:0]    file_mem [FILE_DEPTH];
	logic [7:0]    wreg;
	logic [7:0]    status;
	logic [7:0]    result;
	logic [7:0]    watchdog_counter;
	logic [PRESC_W-1:0] prescaler;
	cpualu_state_t state;
	logic [1:0]    ret_left;

	// ****************************************
	// APB decode
	// ****************************************
	// Zero-wait slave: ready is registered from the setup phase, so every
	// access phase ends at its first edge and never stretches.
	wire setup_ph = psel & ~penable;
	wire wr_acc   = psel & penable & pwrite;
	wire hit_instr  = paddr == `CPUALU_OFF_INSTR;
	wire hit_file   = paddr == `CPUALU_OFF_FILE;
	wire hit_wreg   = paddr == `CPUALU_OFF_WREG;
	wire hit_status = paddr == `CPUALU_OFF_STATUS;
	wire hit_result = paddr == `CPUALU_OFF_RESULT;
	wire hit_wdog   = paddr == `CPUALU_OFF_WDOG;
	wire hit_wake   = paddr == `CPUALU_OFF_WAKE;
	wire mapped = hit_instr | hit_file | hit_wreg | hit_status | hit_result | hit_wdog | hit_wake;

	// ****************************************
	// Instruction decode
	// ****************************************
	wire        asleep   = state == CPUALU_ASLEEP;
	wire        busy     = state == CPUALU_SECOND;
	// Instructions are refused while asleep or finishing a return.
	wire        issue    = wr_acc & hit_instr & (state == CPUALU_RUN);
	wire [3:0]  opc      = pwdata[`CPUALU_OPC_MSB:`CPUALU_OPC_LSB];
	wire        dest     = pwdata[`CPUALU_DEST_BIT];
	wire [6:0]  faddr    = pwdata[`CPUALU_FADDR_MSB:0];
	wire [7:0]  lit      = pwdata[`CPUALU_LIT_MSB:0];
	wire [7:0]  fval     = file_mem[faddr];
	wire [9:0]  sub_f    = sub8(fval, wreg);
	wire [9:0]  sub_l    = sub8(lit, wreg);
	wire        st_c     = status[`CPUALU_ST_C];

	logic [7:0] alu_out;
	logic [7:0] next_status;
	logic       to_file;
	logic       to_w;
	always_comb begin
		alu_out     = 8'h00;
		next_status = status;
		to_file     = 1'b0;
		to_w        = 1'b0;
		case (opc)
			`CPUALU_OP_RROT: begin
				alu_out = {st_c, fval[7:1]};
				next_status[`CPUALU_ST_C] = fval[0];
				to_file = dest;
				to_w    = ~dest;
			end
			`CPUALU_OP_SUB_WREG_FROM_FILE: begin
				alu_out = sub_f[7:0];
				next_status[`CPUALU_ST_C]  = sub_f[8];
				next_status[`CPUALU_ST_DC] = sub_f[9];
				next_status[`CPUALU_ST_Z]  = is_zero(sub_f[7:0]);
				to_file = dest;
				to_w    = ~dest;
			end
			`CPUALU_OP_SUB_WREG_FROM_LITERAL: begin
				alu_out = sub_l[7:0];
				next_status[`CPUALU_ST_C]  = sub_l[8];
				next_status[`CPUALU_ST_DC] = sub_l[9];
				next_status[`CPUALU_ST_Z]  = is_zero(sub_l[7:0]);
				to_w = 1'b1;
			end
			`CPUALU_OP_SWAP: begin
				alu_out = {fval[3:0], fval[7:4]};
				to_file = dest;
				to_w    = ~dest;
			end
			`CPUALU_OP_XOR_LITERAL_WREG: begin
				alu_out = wreg ^ lit;
				next_status[`CPUALU_ST_Z] = is_zero(wreg ^ lit);
				to_w = 1'b1;
			end
			`CPUALU_OP_XOR_WREG_FILE: begin
				alu_out = wreg ^ fval;
				next_status[`CPUALU_ST_Z] = is_zero(wreg ^ fval);
				to_file = dest;
				to_w    = ~dest;
			end
			`CPUALU_OP_SLEEP: begin
				// The default copy of status carries every other flag through.
				next_status[`CPUALU_ST_PD] = 1'b0;
				next_status[`CPUALU_ST_TO] = 1'b1;
			end
			default: begin
				alu_out = 8'h00;
			end
		endcase
	end

	wire do_sleep = issue & (opc == `CPUALU_OP_SLEEP);
	wire do_ret   = issue & (opc == `CPUALU_OP_RET);
	// Wake is a plain register strobe; the real wake-up sources sit outside.
	wire do_wake  = wr_acc & hit_wake & asleep & pwdata[`CPUALU_WAKE_BIT];

	// ****************************************
	// Sequencer
	// ****************************************
	cpualu_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			CPUALU_RUN: begin
				if (do_sleep)
					next_state = CPUALU_ASLEEP;
				else if (do_ret)
					next_state = CPUALU_SECOND;
			end
			CPUALU_SECOND: begin
				if (ret_left <= 2'h1)
					next_state = CPUALU_RUN;
			end
			CPUALU_ASLEEP: begin
				if (do_wake)
					next_state = CPUALU_RUN;
			end
			default: next_state = CPUALU_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= CPUALU_RUN;
			osc_run <= 1'b1;
		end else begin
			state   <= next_state;
			osc_run <= next_state != CPUALU_ASLEEP;
		end
	end

	// ****************************************
	// Return occupancy
	// ****************************************
	// Only the occupancy of a return is modelled; there is no program
	// counter here, so the stack top itself is never read.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ret_left <= 2'h0;
		end else if (do_ret) begin
			ret_left <= `CPUALU_RET_CYCLES - 2'h1;
		end else if (ret_left != 2'h0) begin
			ret_left <= ret_left - 2'h1;
		end
	end

	// ****************************************
	// Datapath registers
	// ****************************************
	// A preload and an instruction use different addresses, so they never
	// share an edge; the instruction branch is still listed first.
	wire       file_poke = wr_acc & hit_file;
	wire [6:0] poke_addr = pwdata[`CPUALU_POKE_ADDR_MSB:`CPUALU_POKE_ADDR_LSB];
	wire [7:0] poke_data = pwdata[`CPUALU_POKE_DATA_MSB:0];
	always_ff @(posedge pclk) begin
		if (issue & to_file)
			file_mem[faddr] <= alu_out;
		else if (file_poke)
			file_mem[poke_addr] <= poke_data;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wreg   <= 8'h00;
			status <= `CPUALU_STATUS_RST;
			result <= 8'h00;
		end else begin
			if (issue & to_w)
				wreg <= alu_out;
			else if (wr_acc & hit_wreg)
				wreg <= pwdata[7:0];
			// A taken instruction owns the flags on its edge.
			if (issue)
				status <= next_status;
			else if (wr_acc & hit_status)
				status[`CPUALU_ST_WR_MSB:0] <= pwdata[`CPUALU_ST_WR_MSB:0];
			if (issue)
				result <= alu_out;
		end
	end

	// ****************************************
	// Watchdog counter and prescaler
	// ****************************************
	// Clocks stop in sleep, so the counter only advances while awake.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_counter <= `CPUALU_WDOG_CLEAR;
			prescaler        <= '0;
			watchdog_clear   <= 1'b0;
		end else begin
			// The pulse lets an outside watchdog restart together with this count.
			watchdog_clear <= do_sleep;
			if (do_sleep) begin
				watchdog_counter <= `CPUALU_WDOG_CLEAR;
				prescaler        <= '0;
			end else if (!asleep) begin
				prescaler <= prescaler + 1'b1;
				if (&prescaler)
					watchdog_counter <= watchdog_counter + 8'h01;
			end
		end
	end

	// ****************************************
	// APB read path
	// ****************************************
	logic [7:0] stat_view;
	always_comb begin
		stat_view                      = 8'h00;
		stat_view[`CPUALU_ST_WR_MSB:0] = status[`CPUALU_ST_WR_MSB:0];
		stat_view[`CPUALU_ST_SLEEP]    = asleep;
		stat_view[`CPUALU_ST_BUSY]     = busy;
	end

	// File readback is a debug aid only and always shows entry 0;
	// a full readback would need an address field of its own.
	wire [7:0]  file_view = file_mem[7'h00];
	wire [31:0] rd_mux =
		hit_file   ? {24'h00_0000, file_view} :
		hit_wreg   ? {24'h00_0000, wreg} :
		hit_status ? {24'h00_0000, stat_view} :
		hit_result ? {24'h00_0000, result} :
		hit_wdog   ? {16'h0000, prescaler[7:0], watchdog_counter} :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			prdata  <= (setup_ph & ~pwrite) ? rd_mux : prdata;
		end
	end

endmodule // cpualu_core

// ==== verilog/cpualu_defs.svh ====
// Constants for the instruction subset datapath: register map, opcodes, flag bits, timings.
`ifndef CPUALU_DEFS_SVH
`define CPUALU_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CPUALU_OFF_INSTR     12'h000
`define CPUALU_OFF_FILE      12'h004
`define CPUALU_OFF_WREG      12'h008
`define CPUALU_OFF_STATUS    12'h00C
`define CPUALU_OFF_RESULT    12'h010
`define CPUALU_OFF_WDOG      12'h014
`define CPUALU_OFF_WAKE      12'h018

// ****************************************
// Instruction word fields
// ****************************************
`define CPUALU_OPC_LSB       12
`define CPUALU_OPC_MSB       15
`define CPUALU_DEST_BIT      7
`define CPUALU_FADDR_MSB     6
`define CPUALU_LIT_MSB       7
`define CPUALU_POKE_ADDR_MSB 14
`define CPUALU_POKE_ADDR_LSB 8
`define CPUALU_POKE_DATA_MSB 7
`define CPUALU_WAKE_BIT      0

// ****************************************
// Opcodes
// ****************************************
`define CPUALU_OP_NOP        4'h0
`define CPUALU_OP_RROT       4'h1
`define CPUALU_OP_SUB_WREG_FROM_FILE      4'h2
`define CPUALU_OP_SUB_WREG_FROM_LITERAL      4'h3
`define CPUALU_OP_SWAP       4'h4
`define CPUALU_OP_XOR_LITERAL_WREG      4'h5
`define CPUALU_OP_XOR_WREG_FILE      4'h6
`define CPUALU_OP_SLEEP      4'h7
`define CPUALU_OP_RET        4'h8

// ****************************************
// Status bit positions, reset values and return timing
// ****************************************
`define CPUALU_ST_C          0
`define CPUALU_ST_DC         1
`define CPUALU_ST_Z          2
`define CPUALU_ST_PD         3
`define CPUALU_ST_TO         4
`define CPUALU_ST_SLEEP      5
`define CPUALU_ST_BUSY       6
`define CPUALU_ST_WR_MSB     4
`define CPUALU_STATUS_RST    8'h18
`define CPUALU_WDOG_CLEAR    8'h00
`define CPUALU_RET_CYCLES    2'h2

`endif

// ==== verilog/cpualu_pkg.sv ====
// Types shared by the instruction subset datapath.
package cpualu_pkg;
	typedef enum logic [1:0] {
		CPUALU_RUN    = 2'b00,
		CPUALU_SECOND = 2'b01,
		CPUALU_ASLEEP = 2'b10
	} cpualu_state_t;
endpackage
